// >>> hw/mfp_map.svh
// Address map, field positions and reset values of the port logic.
// Assumes inclusion from the design, checker and bench files by bare name.
`ifndef MFP_MAP_SVH
`define MFP_MAP_SVH

// ***********************************************
// Port and mode register addresses
// ***********************************************
`define MFP_ADDR_W 4
`define MFP_ADDR_IN_PORT 4'h0
`define MFP_ADDR_OUT_PORT 4'h8
`define MFP_ADDR_BIDI_A 4'ha
`define MFP_ADDR_BIDI_B 4'hb
`define MFP_ADDR_CLK_MODE 4'hc
`define MFP_ADDR_SHIFT_MODE 4'hd

// ***********************************************
// Field positions
// ***********************************************
`define MFP_CLOCK_SELECT_LO 1
`define MFP_CLOCK_SELECT_HI 2
`define MFP_SERIAL_SELECT_LO 1
`define MFP_SERIAL_SELECT_HI 2
`define MFP_EDGE_INPUT_ENABLE 3
`define MFP_EVENT_CLK_CODE 2'h1

// ***********************************************
// Reset values
// ***********************************************
`define MFP_MODE_RST 4'h0
`define MFP_LATCH_RST 4'h0

`endif

// >>> hw/mfp_pkg.sv
// Types shared by the port logic and its bench.
// Assumes the map header sits on the include path.
package mfp_pkg;

    // Per-pin format code of a bidirectional pin
    typedef enum logic [1:0] {
        MFP_FMT_OD,
        MFP_FMT_PP,
        MFP_FMT_OD_PULLUP
    } mfp_fmt_t;

    // Serial pin assignment from the serial select bits
    typedef enum logic [1:0] {
        MFP_SER_OFF,
        MFP_SER_EXT_CLK,
        MFP_SER_INT_CLK,
        MFP_SER_INT_CLK_ALT
    } mfp_ser_t;

    typedef logic [3:0] mfp_nibble_t;

endpackage

// >>> hw/mfp_port_logic.sv
// Port logic of a small 4-bit controller: input port, output latch port
// and two quasi-bidirectional ports, reached by the core's port strobes.
// Assumes pin inputs synchronous to clk_in and a core that issues one
// port instruction per strobe, with the port address from its low register.
`include "mfp_map.svh"
`timescale 1ns/1ns
`default_nettype none

module mfp_port_logic #(
    parameter logic [3:0] OUT_PUSH_PULL = 4'hf,      // 1 = push-pull output bit
    parameter logic [7:0] BIDI_A_FMT = 8'h55,        // 2 bits per pin, format code
    parameter logic [7:0] BIDI_B_FMT = 8'h55,        // 2 bits per pin, format code
    parameter bit OSC_RESISTOR_PIN = 1'b0            // 1 = top output pin is oscillator
) (
    input wire logic clk_in,                         // Core clock, 20 MHz
    input wire logic resetn_in,                      // Sync reset, active low
    input wire logic [`MFP_ADDR_W-1:0] addr_in,      // Port address from low register
    input wire mfp_pkg::mfp_nibble_t wdata_in,       // Accumulator / bit index
    input wire logic we_in,                          // Port output instruction
    input wire logic re_in,                          // Port input instruction
    input wire logic bit_set_in,                     // Port bit set instruction
    input wire logic bit_clr_in,                     // Port bit reset instruction
    output logic [3:0] rdata_out,                    // Read data, cycle after read
    input wire logic [3:0] in_port_in,               // Input port pin levels
    output logic [3:0] in_port_out,                  // Input port drive value
    output logic [3:0] in_port_oe_n_out,             // Input port drive enable, low
    input wire logic ser_clk_in,                     // Serial unit clock to pin
    input wire logic ser_data_in,                    // Serial unit data to pin
    output logic ser_clk_out,                        // Pin clock to serial unit
    output logic ser_data_out,                       // Pin data to serial unit
    output logic [1:0] serial_mode_out,              // Serial select bits
    output logic timer_count_clk_out,                // Event clock to timer
    output logic [1:0] clock_select_out,             // Clock select bits to timer
    output logic edge_test_out,                      // Rising edge seen, one pulse
    output logic [3:0] out_port_out,                 // Output port drive value
    output logic [3:0] out_port_oe_n_out,            // Output port enable, low
    input wire logic [3:0] bidi_a_in,                // Bidirectional A pin levels
    output logic [3:0] bidi_a_out,                   // Bidirectional A drive value
    output logic [3:0] bidi_a_oe_n_out,              // Bidirectional A enable, low
    output logic [3:0] bidi_a_pullup_out,            // Bidirectional A pull-up on
    input wire logic [3:0] bidi_b_in,                // Bidirectional B pin levels
    output logic [3:0] bidi_b_out,                   // Bidirectional B drive value
    output logic [3:0] bidi_b_oe_n_out,              // Bidirectional B enable, low
    output logic [3:0] bidi_b_pullup_out             // Bidirectional B pull-up on
);
    import mfp_pkg::*;

    // ***********************************************
    // Elaboration checks
    // ***********************************************
    function automatic bit fmt_ok(input logic [7:0] f);
        bit ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (f[2*i +: 2] == 2'h3) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    if (!fmt_ok(BIDI_A_FMT) || !fmt_ok(BIDI_B_FMT)) begin : g_bad_fmt
        $error("Bidirectional format code 3 is not defined");
    end

    // ***********************************************
    // Helper functions
    // ***********************************************
    // Rewrite one latch bit, others keep their content
    function automatic mfp_nibble_t bit_update(input mfp_nibble_t latch,
                                               input logic [1:0] idx,
                                               input logic val);
        mfp_nibble_t res;
        res = latch;
        res[idx] = val;
        return res;
    endfunction

    // Pins driving high or low for a format map; open-drain only pulls low
    function automatic mfp_nibble_t bidi_oe_n(input mfp_nibble_t latch,
                                              input logic [7:0] fmt,
                                              input logic written);
        mfp_nibble_t res;
        res = 4'hf;
        for (int i = 0; i < 4; i++) begin
            if (written) begin
                if (mfp_fmt_t'(fmt[2*i +: 2]) == MFP_FMT_PP) begin
                    res[i] = 1'b0;
                end else begin
                    res[i] = latch[i];
                end
            end
        end
        return res;
    endfunction

    function automatic mfp_nibble_t pullup_map(input logic [7:0] fmt);
        mfp_nibble_t res;
        res = 4'h0;
        for (int i = 0; i < 4; i++) begin
            res[i] = (mfp_fmt_t'(fmt[2*i +: 2]) == MFP_FMT_OD_PULLUP);
        end
        return res;
    endfunction

    // ***********************************************
    // State
    // ***********************************************
    mfp_nibble_t clk_mode_r;
    mfp_nibble_t shift_mode_r;
    mfp_nibble_t out_latch_r;
    mfp_nibble_t bidi_a_latch_r;
    mfp_nibble_t bidi_b_latch_r;
    logic out_written_r;
    logic bidi_a_written_r;
    logic bidi_b_written_r;
    logic in_bit0_prev_r;
    logic edge_test_r;
    logic event_clk_r;
    logic ser_clk_r;
    logic ser_data_r;
    mfp_nibble_t rdata_r;

    // ***********************************************
    // Decode
    // ***********************************************
    wire logic sel_out = (addr_in == `MFP_ADDR_OUT_PORT);
    wire logic sel_bidi_a = (addr_in == `MFP_ADDR_BIDI_A);
    wire logic sel_bidi_b = (addr_in == `MFP_ADDR_BIDI_B);
    wire logic sel_clk_mode = (addr_in == `MFP_ADDR_CLK_MODE);
    wire logic sel_shift_mode = (addr_in == `MFP_ADDR_SHIFT_MODE);
    wire logic bit_op = bit_set_in | bit_clr_in;
    wire logic [1:0] bit_idx = wdata_in[1:0];
    wire logic bit_val = bit_set_in;

    // Top output bit absent when the pin serves the oscillator
    wire mfp_nibble_t out_mask = OSC_RESISTOR_PIN ? 4'h7 : 4'hf;

    // Bit ops merge into the full latch so untouched pins keep their value
    wire mfp_nibble_t out_latch_nxt =
        we_in ? (wdata_in & out_mask) :
        bit_update(out_latch_r, bit_idx, bit_val) & out_mask;
    wire mfp_nibble_t bidi_a_latch_nxt =
        we_in ? wdata_in : bit_update(bidi_a_latch_r, bit_idx, bit_val);
    wire mfp_nibble_t bidi_b_latch_nxt =
        we_in ? wdata_in : bit_update(bidi_b_latch_r, bit_idx, bit_val);
    wire logic out_wr = (we_in | bit_op) & sel_out;
    wire logic bidi_a_wr = (we_in | bit_op) & sel_bidi_a;
    wire logic bidi_b_wr = (we_in | bit_op) & sel_bidi_b;

    wire logic [1:0] clock_select =
        {clk_mode_r[`MFP_CLOCK_SELECT_HI], clk_mode_r[`MFP_CLOCK_SELECT_LO]};
    wire mfp_ser_t serial_mode = mfp_ser_t'(
        {shift_mode_r[`MFP_SERIAL_SELECT_HI], shift_mode_r[`MFP_SERIAL_SELECT_LO]});
    wire logic edge_enable = shift_mode_r[`MFP_EDGE_INPUT_ENABLE];
    wire logic ser_int_clk = (serial_mode == MFP_SER_INT_CLK) ||
                             (serial_mode == MFP_SER_INT_CLK_ALT);

    // Read mux: pins for input-capable ports, latch for the output port
    wire mfp_nibble_t rd_mux =
        (addr_in == `MFP_ADDR_IN_PORT) ? in_port_in :
        sel_out ? out_latch_r :
        sel_bidi_a ? bidi_a_in :
        sel_bidi_b ? bidi_b_in :
        sel_clk_mode ? clk_mode_r :
        sel_shift_mode ? shift_mode_r : 4'h0;

    // ***********************************************
    // Mode registers and latches
    // ***********************************************
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            clk_mode_r <= `MFP_MODE_RST;
            shift_mode_r <= `MFP_MODE_RST;
        end else if (we_in) begin
            if (sel_clk_mode) begin
                clk_mode_r <= wdata_in;
            end
            if (sel_shift_mode) begin
                shift_mode_r <= wdata_in;
            end
        end
    end

    // Latch content counts as undefined after reset; zero is one such value
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            out_latch_r <= `MFP_LATCH_RST;
            out_written_r <= 1'b0;
        end else if (out_wr) begin
            out_latch_r <= out_latch_nxt;
            out_written_r <= 1'b1;
        end
    end

    // Reads never touch these; only writes or reset change them
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            bidi_a_latch_r <= `MFP_LATCH_RST;
            bidi_a_written_r <= 1'b0;
        end else if (bidi_a_wr) begin
            bidi_a_latch_r <= bidi_a_latch_nxt;
            bidi_a_written_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            bidi_b_latch_r <= `MFP_LATCH_RST;
            bidi_b_written_r <= 1'b0;
        end else if (bidi_b_wr) begin
            bidi_b_latch_r <= bidi_b_latch_nxt;
            bidi_b_written_r <= 1'b1;
        end
    end

    // ***********************************************
    // Input port alternate functions
    // ***********************************************
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            in_bit0_prev_r <= 1'b0;
            edge_test_r <= 1'b0;
            event_clk_r <= 1'b0;
            ser_clk_r <= 1'b0;
            ser_data_r <= 1'b0;
        end else begin
            in_bit0_prev_r <= in_port_in[0];
            edge_test_r <= edge_enable & in_port_in[0] & ~in_bit0_prev_r;
            event_clk_r <= (clock_select == `MFP_EVENT_CLK_CODE) &
                           in_port_in[0];
            ser_clk_r <= (serial_mode == MFP_SER_OFF) ? 1'b0 :
                         (ser_int_clk ? ser_clk_in : in_port_in[1]);
            ser_data_r <= (serial_mode != MFP_SER_OFF) & in_port_in[3];
        end
    end

    // ***********************************************
    // Read data
    // ***********************************************
    // Data stands one cycle after the read strobe only
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rdata_r <= 4'h0;
        end else if (re_in) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 4'h0;
        end
    end

    // ***********************************************
    // Pin drive
    // ***********************************************
    // Serial clock pin drives only with the internal clock; data pin in any mode but off
    assign in_port_out = {1'b0, ser_data_in, ser_clk_in, 1'b0};
    assign in_port_oe_n_out = {1'b1, serial_mode == MFP_SER_OFF,
                               ~ser_int_clk, 1'b1};

    // Open-drain bits pull low only; high is left to the board
    always_comb begin
        out_port_out = out_latch_r & OUT_PUSH_PULL;
        out_port_oe_n_out = 4'hf;
        for (int i = 0; i < 4; i++) begin
            if (out_written_r && out_mask[i]) begin
                out_port_oe_n_out[i] = OUT_PUSH_PULL[i] ? 1'b0 :
                                       out_latch_r[i];
            end
        end
    end

    // Push-pull pins stay driven after the first write until reset
    assign bidi_a_oe_n_out = bidi_oe_n(bidi_a_latch_r, BIDI_A_FMT,
                                       bidi_a_written_r);
    assign bidi_b_oe_n_out = bidi_oe_n(bidi_b_latch_r, BIDI_B_FMT,
                                       bidi_b_written_r);
    assign bidi_a_out = bidi_a_latch_r;
    assign bidi_b_out = bidi_b_latch_r;
    assign bidi_a_pullup_out = pullup_map(BIDI_A_FMT);
    assign bidi_b_pullup_out = pullup_map(BIDI_B_FMT);

    // ***********************************************
    // Outputs to timer, serial unit and core
    // ***********************************************
    assign rdata_out = rdata_r;
    assign timer_count_clk_out = event_clk_r;
    assign clock_select_out = clock_select;
    assign edge_test_out = edge_test_r;
    assign ser_clk_out = ser_clk_r;
    assign ser_data_out = ser_data_r;
    assign serial_mode_out = serial_mode;

endmodule

`default_nettype wire

// >>> test/mfp_port_logic_props.sv
// Checker of the port logic, bound to every instance of its top module.
// Assumes the map header on the include path and a synchronous reset.
`include "mfp_map.svh"
`timescale 1ns/1ns
`default_nettype none

module mfp_port_logic_props #(
    parameter logic [3:0] OUT_PUSH_PULL = 4'hf,
    parameter logic [7:0] BIDI_A_FMT = 8'h55,
    parameter bit OSC_RESISTOR_PIN = 1'b0
) (
    input wire logic clk_in, resetn_in, we_in, re_in, bit_set_in, bit_clr_in,
    input wire logic [`MFP_ADDR_W-1:0] addr_in,
    input wire mfp_pkg::mfp_nibble_t wdata_in,
    input wire logic [3:0] rdata_out, in_port_in, in_port_oe_n_out, out_port_out,
    input wire logic [3:0] out_port_oe_n_out, bidi_a_out, bidi_a_oe_n_out,
    input wire logic [1:0] serial_mode_out, clock_select_out,
    input wire logic ser_data_out, timer_count_clk_out, edge_test_out
);
    import mfp_pkg::*;
    localparam logic [3:0] OMASK = OSC_RESISTOR_PIN ? 4'h7 : 4'hf;
    wire logic [3:0] pp_a = {BIDI_A_FMT[7:6] == 2'h1, BIDI_A_FMT[5:4] == 2'h1,
        BIDI_A_FMT[3:2] == 2'h1, BIDI_A_FMT[1:0] == 2'h1};
    // Latch as seen at the pins: only valid once the port has been written
    wire logic [3:0] latch8 = (out_port_out & OUT_PUSH_PULL)
        | (out_port_oe_n_out & ~OUT_PUSH_PULL & OMASK);
    wire logic [3:0] pick = 4'h1 << wdata_in[1:0];
    wire logic port8 = addr_in == `MFP_ADDR_OUT_PORT;
    // ********
    // Assertions
    // ********
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_out_wr; we_in && port8; endsequence
    sequence s_out_bit; (bit_set_in || bit_clr_in) && port8; endsequence
    sequence s_bidi_rd; re_in && addr_in inside {`MFP_ADDR_BIDI_A, `MFP_ADDR_BIDI_B}; endsequence
    a_in_read_pins: assert property (
        re_in && addr_in == `MFP_ADDR_IN_PORT |=> rdata_out == $past(in_port_in))
        else $error("input port read differs from pins");
    a_event_clk_route: assert property (
        1'b1 |=> timer_count_clk_out == ($past(clock_select_out) == 2'h1 && $past(in_port_in[0])))
        else $error("timer count clock wrong");
    a_edge_one_pulse: assert property (
        edge_test_out |-> $past(in_port_in[0]) && !$past(in_port_in[0], 2))
        else $error("edge pulse without rising edge");
    a_serial_pin_use: assert property (
        in_port_oe_n_out == {1'b1, serial_mode_out == 2'h0, !serial_mode_out[1], 1'b1})
        else $error("serial pin enables wrong");
    a_serial_data_in: assert property (
        1'b1 |=> ser_data_out == ($past(serial_mode_out) != 2'h0 && $past(in_port_in[3])))
        else $error("serial data from pin wrong");
    a_out_write_drive: assert property (
        s_out_wr |=> out_port_out == ($past(wdata_in) & OMASK & OUT_PUSH_PULL)
        && out_port_oe_n_out == (($past(wdata_in) & OMASK & ~OUT_PUSH_PULL) | ~OMASK))
        else $error("output port write not driven");
    a_out_bit_change: assert property (
        s_out_bit |=> latch8 == (($past(bit_set_in) ? $past(latch8) | $past(pick)
        : $past(latch8) & ~$past(pick)) & OMASK))
        else $error("bit operation changed wrong bits");
    a_bidi_read_keeps: assert property (
        s_bidi_rd |=> $stable(bidi_a_out) && $stable(bidi_a_oe_n_out))
        else $error("read disturbed bidirectional port");
    a_bidi_write_fmt: assert property (
        we_in && addr_in == `MFP_ADDR_BIDI_A |=> bidi_a_out == $past(wdata_in)
        && bidi_a_oe_n_out == ($past(wdata_in) & ~pp_a))
        else $error("bidirectional write format wrong");
    a_pp_keeps_drive: assert property (
        (bidi_a_oe_n_out & pp_a) == 4'h0 |=> (bidi_a_oe_n_out & pp_a) == 4'h0)
        else $error("push-pull pin stopped driving");
    a_reset_floats: assert property (disable iff (1'b0)
        !resetn_in |=> out_port_oe_n_out == 4'hf && bidi_a_oe_n_out == 4'hf && rdata_out == 4'h0)
        else $error("pins driven after reset");
endmodule

bind mfp_port_logic mfp_port_logic_props #(.OUT_PUSH_PULL(OUT_PUSH_PULL),
    .BIDI_A_FMT(BIDI_A_FMT), .OSC_RESISTOR_PIN(OSC_RESISTOR_PIN)) u_props (
    .clk_in(clk_in), .resetn_in(resetn_in), .we_in(we_in), .re_in(re_in),
    .bit_set_in(bit_set_in), .bit_clr_in(bit_clr_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .in_port_in(in_port_in), .in_port_oe_n_out(in_port_oe_n_out),
    .out_port_out(out_port_out), .out_port_oe_n_out(out_port_oe_n_out),
    .bidi_a_out(bidi_a_out), .bidi_a_oe_n_out(bidi_a_oe_n_out),
    .serial_mode_out(serial_mode_out), .clock_select_out(clock_select_out),
    .ser_data_out(ser_data_out), .timer_count_clk_out(timer_count_clk_out),
    .edge_test_out(edge_test_out));
`default_nettype wire

// >>> test/mfp_pin_model.sv
// Board side of four port pins: device drive, board drive, pull-up.
// Assumes the device drives a pin only while its enable is low.
`timescale 1ns/1ns
`default_nettype none

module mfp_pin_model (
    input wire logic clk_in,             // Core clock
    input wire logic [3:0] drv_in,       // Device drive value
    input wire logic [3:0] oe_n_in,      // Device enable, low
    input wire logic [3:0] pullup_in,    // Internal pull-up on
    input wire logic [3:0] ext_in,       // Board drive value
    input wire logic [3:0] ext_en_in,    // Board drives pin
    output logic [3:0] lvl_out           // Resolved pin level
);
    // ********
    // Pin resolution
    // ********
    logic [3:0] float_r = 4'h0;
    // Floating pins toggle so a stale level never reads as data
    always_ff @(posedge clk_in) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!oe_n_in[i]) lvl_out[i] = drv_in[i];
            else if (ext_en_in[i]) lvl_out[i] = ext_in[i];
            else if (pullup_in[i]) lvl_out[i] = 1'b1;
            else lvl_out[i] = float_r[i];
        end
    end
endmodule
`default_nettype wire

// >>> test/mfp_port_logic_bench.sv
// Self-checking bench of the port logic with pin models on the input port and both bidirectional ports.
// Assumes the map header on the include path.
`include "mfp_map.svh"
`timescale 1ns/1ns
`default_nettype none

module mfp_port_logic_bench;
    import mfp_pkg::*;
    localparam logic [3:0] PP8 = 4'h5;
    // Pin 0 open-drain, 1 push-pull, 2 open-drain with pull-up, 3 push-pull
    localparam logic [7:0] FMT_A = 8'h64;
    localparam logic [3:0] WR = 4'h8, RD = 4'h4, SET = 4'h2, CLR = 4'h1;
    logic clk = 1'b0, resetn = 1'b0, we = 1'b0, re = 1'b0, bset = 1'b0, bclr = 1'b0;
    logic ser_clk = 1'b0, ser_data = 1'b0, ser_clk_o, ser_data_o, tmr_clk, edge_p;
    logic [3:0] addr = 4'h0, ext0 = 4'h0, ext_a = 4'h0, ext_a_en = 4'h0;
    logic [3:0] ext_b = 4'h0, ext_b_en = 4'h0;
    mfp_nibble_t wdata = 4'h0;
    logic [3:0] rdata, lvl0, lvl_a, lvl_b, p0_drv, p0_oe_n, p8, p8_oe_n;
    logic [3:0] a_drv, a_oe_n, a_pu, b_drv, b_oe_n, b_pu;
    logic [1:0] ser_mode, clk_sel;
    int failures = 0, n_compared = 0;

    initial forever #25 clk = ~clk;
    mfp_port_logic #(.OUT_PUSH_PULL(PP8), .BIDI_A_FMT(FMT_A), .BIDI_B_FMT(8'h55),
        .OSC_RESISTOR_PIN(1'b0)) u_dut (.clk_in(clk), .resetn_in(resetn), .addr_in(addr),
        .wdata_in(wdata), .we_in(we), .re_in(re), .bit_set_in(bset), .bit_clr_in(bclr),
        .rdata_out(rdata), .in_port_in(lvl0), .in_port_out(p0_drv), .in_port_oe_n_out(p0_oe_n),
        .ser_clk_in(ser_clk), .ser_data_in(ser_data), .ser_clk_out(ser_clk_o),
        .ser_data_out(ser_data_o), .serial_mode_out(ser_mode), .timer_count_clk_out(tmr_clk),
        .clock_select_out(clk_sel), .edge_test_out(edge_p), .out_port_out(p8),
        .out_port_oe_n_out(p8_oe_n), .bidi_a_in(lvl_a), .bidi_a_out(a_drv),
        .bidi_a_oe_n_out(a_oe_n), .bidi_a_pullup_out(a_pu), .bidi_b_in(lvl_b),
        .bidi_b_out(b_drv), .bidi_b_oe_n_out(b_oe_n), .bidi_b_pullup_out(b_pu));
    mfp_pin_model u_pins0 (.clk_in(clk), .drv_in(p0_drv), .oe_n_in(p0_oe_n),
        .pullup_in(4'h0), .ext_in(ext0), .ext_en_in(4'hf), .lvl_out(lvl0));
    mfp_pin_model u_pins_a (.clk_in(clk), .drv_in(a_drv), .oe_n_in(a_oe_n),
        .pullup_in(a_pu), .ext_in(ext_a), .ext_en_in(ext_a_en), .lvl_out(lvl_a));
    mfp_pin_model u_pins_b (.clk_in(clk), .drv_in(b_drv), .oe_n_in(b_oe_n),
        .pullup_in(b_pu), .ext_in(ext_b), .ext_en_in(ext_b_en), .lvl_out(lvl_b));

    // ********
    // Bus and check tasks
    // ********
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One strobe per call; the answer stands when the task returns
    task automatic bus(input logic [3:0] k, input logic [3:0] a, input mfp_nibble_t d);
        @(posedge clk);
        {we, re, bset, bclr} <= k;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        {we, re, bset, bclr} <= 4'h0;
        #1;
    endtask
    task automatic test_done;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic t_out_port;
        bus(WR, `MFP_ADDR_OUT_PORT, 4'ha);
        chk(p8, 4'ha & PP8);
        chk(p8_oe_n, 4'ha & ~PP8);
        bus(SET, `MFP_ADDR_OUT_PORT, 4'h0);
        chk(p8, 4'hb & PP8);
        bus(CLR, `MFP_ADDR_OUT_PORT, 4'h3);
        chk(p8_oe_n, 4'h3 & ~PP8);
        bus(WR, 4'h5, 4'hf);
        bus(WR, `MFP_ADDR_IN_PORT, 4'hf);
        bus(RD, 4'h5, 4'h0);
        chk(rdata, 4'h0);
        bus(RD, `MFP_ADDR_OUT_PORT, 4'h0);
        chk(rdata, 4'h3);
        $display("t_out_port done");
    endtask
    task automatic t_bidi;
        ext_a <= 4'h1;
        ext_a_en <= 4'h1;
        bus(WR, `MFP_ADDR_BIDI_A, 4'h5);
        chk(a_oe_n, 4'h5);
        chk(a_pu, 4'h4);
        bus(RD, `MFP_ADDR_BIDI_A, 4'h0);
        chk(rdata, 4'h5);
        chk(a_drv, 4'h5);
        bus(WR, `MFP_ADDR_BIDI_A, 4'h0);
        bus(SET, `MFP_ADDR_BIDI_A, 4'h1);
        chk(a_oe_n, 4'h0);
        bus(RD, `MFP_ADDR_BIDI_A, 4'h0);
        chk(rdata, 4'h2);
        bus(WR, `MFP_ADDR_BIDI_B, 4'h9);
        bus(RD, `MFP_ADDR_BIDI_B, 4'h0);
        chk(rdata, 4'h9);
        $display("t_bidi done");
    endtask
    task automatic t_serial;
        ext0 <= 4'h9;
        ser_clk <= 1'b1;
        bus(WR, `MFP_ADDR_SHIFT_MODE, 4'h6);
        chk(p0_oe_n, 4'h9);
        bus(RD, `MFP_ADDR_IN_PORT, 4'h0);
        chk(rdata, 4'hb);
        chk({3'h0, ser_data_o}, 4'h1);
        bus(WR, `MFP_ADDR_SHIFT_MODE, 4'h2);
        ext0 <= 4'hb;
        bus(RD, `MFP_ADDR_IN_PORT, 4'h0);
        chk(p0_oe_n, 4'hb);
        chk({3'h0, ser_clk_o}, 4'h1);
        $display("t_serial done");
    endtask
    task automatic t_count;
        int n;
        bus(WR, `MFP_ADDR_CLK_MODE, 4'h2);
        @(posedge clk) ext0 <= 4'h1;
        repeat (2) @(posedge clk);
        #1 chk({3'h0, tmr_clk}, 4'h1);
        bus(WR, `MFP_ADDR_CLK_MODE, 4'h4);
        @(posedge clk);
        #1 chk({3'h0, tmr_clk}, 4'h0);
        for (int e = 0; e < 2; e++) begin
            bus(WR, `MFP_ADDR_SHIFT_MODE, (e == 0) ? 4'h8 : 4'h0);
            @(posedge clk) ext0 <= 4'h0;
            @(posedge clk) ext0 <= 4'h1;
            n = 0;
            repeat (4) begin
                @(posedge clk);
                #1 n += edge_p;
            end
            chk(n[3:0], (e == 0) ? 4'h1 : 4'h0);
        end
        $display("t_count done");
    endtask
    task automatic t_reset_mid;
        @(posedge clk) resetn <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(p8_oe_n, 4'hf);
        chk(a_oe_n, 4'hf);
        @(posedge clk) resetn <= 1'b1;
        bus(RD, `MFP_ADDR_BIDI_A, 4'h0);
        chk({3'h0, rdata[2]}, 4'h1);
        // Port B released by reset: the board level must come through
        ext_b <= 4'h6;
        ext_b_en <= 4'hf;
        bus(RD, `MFP_ADDR_BIDI_B, 4'h0);
        chk(rdata, 4'h6);
        $display("t_reset_mid done");
    endtask

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_out_port;
        t_bidi;
        t_serial;
        t_count;
        t_reset_mid;
        test_done;
    end
    // A run needs well under 300 cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done;
    end
endmodule
`default_nettype wire
